// ---- dv/pqm_dma_client.sv ----
// Model of one DMA port client of the queue manager
`timescale 1ns/10ps
module pqm_dma_client (
    // Clock and handshake
    input  wire logic             i_clk,
    input  wire logic             i_ready,
    // Request
    output pqm_pkg::pqm_dma_req_s o_req
);
    initial o_req = '0;
    task automatic op(input logic w, input logic [1:0] p,
        input logic [5:0] q, input logic [31:0] d, output logic ok);
        int n;
        @(posedge i_clk);
        o_req <= '{1'b1, w, p, q, d};
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge i_clk);
            ok = (i_ready === 1'b1);
        end
        // Released lines show the inverse of the last request
        o_req <= '{1'b0, ~w, ~p, ~q, ~d};
    endtask
endmodule // pqm_dma_client

// ---- dv/pqm_queue_manager_properties.sv ----
// Port checks of the packet queue manager
`timescale 1ns/10ps
module pqm_qm_chk (
    // Clock, reset, enable
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic                  i_ce,
    // Bus, DMA and interrupt ports
    input wire pqm_pkg::pqm_avm_req_s i_avm,
    input wire logic                  o_waitrequest,
    input wire logic [31:0]           o_readdata,
    input wire pqm_pkg::pqm_dma_req_s i_dma,
    input wire logic                  o_dma_ready,
    input wire pqm_pkg::pqm_dma_rsp_s o_dma_rsp,
    input wire logic                  o_cmpl_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Answered push onto queues 24 to 27
    wire cq = (!o_waitrequest && i_avm.write && i_avm.address[3:0] == 4'hC
        && i_avm.address[13:6] == 8'h86)
        || (o_dma_ready && i_dma.write && i_dma.queue[5:2] == 4'h6);
    property p_wait_one; !o_waitrequest |=> o_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("bus answer too long");
    property p_wait_req; !o_waitrequest |-> i_avm.read || i_avm.write;
    endproperty
    a_wait_req: assert property (p_wait_req)
        else $error("bus answer without request");
    property p_bus_bound; disable iff (i_rst || !i_ce)
        (i_avm.read || i_avm.write) |-> ##[0:4] !o_waitrequest; endproperty
    a_bus_bound: assert property (p_bus_bound)
        else $error("bus request not answered");
    property p_rdy_one; o_dma_ready |=> !o_dma_ready; endproperty
    a_rdy_one: assert property (p_rdy_one)
        else $error("dma ready too long");
    property p_rdy_req; o_dma_ready |-> i_dma.valid; endproperty
    a_rdy_req: assert property (p_rdy_req)
        else $error("dma ready without request");
    property p_empty; o_dma_ready && !i_dma.write && o_dma_rsp.empty
        |-> o_dma_rsp.ptr == 32'h0000_0000; endproperty
    a_empty: assert property (p_empty)
        else $error("empty pop gave pointer");
    property p_port; o_dma_ready && i_dma.queue[5:3] == 3'h2
        && i_dma.queue[2:1] != i_dma.port |-> o_dma_rsp.err; endproperty
    a_port: assert property (p_port)
        else $error("foreign submit queue accepted");
    property p_irq; o_cmpl_irq |-> cq || $past(cq); endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without completion push");
endmodule // pqm_qm_chk
bind pqm_queue_manager pqm_qm_chk u_chk (.i_clk, .i_rst, .i_ce, .i_avm,
    .o_waitrequest, .o_readdata, .i_dma, .o_dma_ready, .o_dma_rsp,
    .o_cmpl_irq);

// ---- dv/tb_top.sv ----
// Self-checking bench of the packet queue manager
`timescale 1ns/10ps
module tb_top;
    logic                  i_clk = 1'b0;
    logic                  i_rst = 1'b1;
    pqm_pkg::pqm_avm_req_s avm = '0;
    pqm_pkg::pqm_dma_req_s dreq;
    pqm_pkg::pqm_dma_rsp_s rsp, er;
    pqm_pkg::pqm_dma_rsp_s exp_dma[$];
    logic [31:0]           exp_bus[$];
    logic                  wreq, rdy, irq, ok;
    logic [31:0]           rdat, p0, p1, p2;
    logic [31:0]           pa[4], pb[4];
    logic [5:0]            qs[4] = '{6'h00, 6'h11, 6'h1C, 6'h3F};
    logic [8:0]            cnt = '0;
    int                    seed = 46405;
    int                    mismatches = 0;
    int                    checked = 0;
    int                    irq_n = 0;
    always #50 i_clk = ~i_clk;
    pqm_queue_manager DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_avm(avm), .o_waitrequest(wreq), .o_readdata(rdat), .i_dma(dreq),
        .o_dma_ready(rdy), .o_dma_rsp(rsp), .o_cmpl_irq(irq));
    pqm_dma_client dma (.i_clk(i_clk), .i_ready(rdy), .o_req(dreq));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [13:0] a,
        input logic [31:0] d);
        int n;
        @(posedge i_clk);
        avm <= '{!w, w, a, d, pqm_pkg::BE_FULL};
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (wreq === 1'b0) break;
        end
        if (n == 20) begin
            mismatches++;
            wrap_up();
        end
        avm <= '{1'b0, 1'b0, ~a, ~d, 4'h0};
    endtask
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [13:0] a, input logic [31:0] e);
        exp_bus.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    function automatic logic [13:0] qa(input logic [5:0] q,
        input logic [3:0] r);
        return pqm_pkg::A_QUEUE | {q, r};
    endfunction
    task automatic push(input logic [5:0] q, output logic [31:0] p);
        p = 32'h0001_0000 | {cnt, 5'h00} | ({$random(seed)} & 32'h1F);
        cnt++;
        wr(qa(q, pqm_pkg::QREG_PUSHPOP), p);
    endtask
    task automatic dop(input logic w, input logic [1:0] pt,
        input logic [5:0] q, input logic [31:0] d, input logic [33:0] e);
        exp_dma.push_back(e);
        dma.op(w, pt, q, d, ok);
        if (!ok) begin
            mismatches++;
            wrap_up();
        end
    endtask
    always @(posedge i_clk) begin
        if (irq === 1'b1)
            irq_n++;
        if (wreq === 1'b0 && avm.read)
            check(rdat, exp_bus.pop_front());
        if (rdy === 1'b1 && dreq.valid) begin
            er = exp_dma.pop_front();
            check(rsp.err, er.err);
            if (!dreq.write)
                check({rsp.ptr, rsp.empty}, {er.ptr, er.empty});
        end
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        wr(pqm_pkg::A_LBASE1, 32'h0002_0003);
        rd(pqm_pkg::A_LBASE1, 32'h0002_0000);
        wr(pqm_pkg::A_REGION | pqm_pkg::RREG_BASE, 32'h0001_0000);
        wr(pqm_pkg::A_REGION | pqm_pkg::RREG_COUNT, 32'h0000_0040);
        wr(pqm_pkg::A_REGION | pqm_pkg::RREG_CTRL, 32'h0000_0000);
        wr(pqm_pkg::A_LSIZE1, 32'h0000_0028);
        rd(pqm_pkg::A_LSIZE1, 32'h0000_0028);
        rd(pqm_pkg::A_LSIZE2, 32'h0000_0018);
        rd(pqm_pkg::A_LBASE2, 32'h0000_0000);
        rd(14'h0030, 32'h0000_0000);
        $display("test config done");
        for (int i = 0; i < 4; i++) begin
            push(qs[i], pa[i]);
            push(qs[i], pb[i]);
            rd(qa(qs[i], pqm_pkg::QREG_COUNT), 32'h0000_0002);
        end
        for (int i = 0; i < 4; i++) begin
            rd(qa(qs[i], pqm_pkg::QREG_PEEK), pa[i]);
            rd(qa(qs[i], pqm_pkg::QREG_PUSHPOP), pa[i]);
            rd(qa(qs[i], pqm_pkg::QREG_PUSHPOP), pb[i]);
            rd(qa(qs[i], pqm_pkg::QREG_PUSHPOP), 32'h0000_0000);
        end
        $display("test queues done");
        for (int q = 24; q < 29; q++) begin
            push(6'(q), p0);
            rd(qa(6'(q), pqm_pkg::QREG_PUSHPOP), p0);
        end
        repeat (2) @(posedge i_clk);
        check(irq_n, 4);
        $display("test interrupt done");
        push(6'h1E, p0);
        push(6'h1E, p1);
        push(6'h1F, p2);
        wr(pqm_pkg::A_DIVERT, {1'b0, 9'h000, 6'h1F, 10'h000, 6'h1E});
        rd(qa(6'h1F, pqm_pkg::QREG_PUSHPOP), p2);
        rd(qa(6'h1F, pqm_pkg::QREG_PUSHPOP), p0);
        rd(qa(6'h1F, pqm_pkg::QREG_PUSHPOP), p1);
        push(6'h20, p0);
        push(6'h21, p1);
        push(6'h21, p2);
        wr(pqm_pkg::A_DIVERT, {1'b1, 9'h000, 6'h20, 10'h000, 6'h21});
        rd(qa(6'h20, pqm_pkg::QREG_PUSHPOP), p1);
        rd(qa(6'h20, pqm_pkg::QREG_PUSHPOP), p2);
        rd(qa(6'h20, pqm_pkg::QREG_PUSHPOP), p0);
        $display("test diversion done");
        p0 = 32'h0001_0000 | {cnt, 5'h00};
        cnt++;
        dop(1'b1, 2'h0, 6'h10, p0, '0);
        dop(1'b1, 2'h1, 6'h10, p0 ^ 32'h20, 34'h1);
        dop(1'b0, 2'h0, 6'h10, '0, {p0, 2'b00});
        dop(1'b0, 2'h0, 6'h10, '0, 34'h2);
        push(6'h00, p1);
        dop(1'b0, 2'h3, 6'h00, '0, {p1, 2'b00});
        p2 = 32'h0001_0000 | {cnt, 5'h00};
        dop(1'b1, 2'h2, 6'h18, p2, '0);
        rd(qa(6'h18, pqm_pkg::QREG_PUSHPOP), p2);
        rd(pqm_pkg::A_LADDR, 32'h0002_0054);
        repeat (2) @(posedge i_clk);
        check(irq_n, 5);
        $display("test dma port done");
        wrap_up();
    end
endmodule // tb_top

// ---- verilog/pqm_pkg.sv ----
// Constants, types and register map of the packet queue manager
package pqm_pkg;

    localparam int NQ     = 64;
    localparam int NREGN  = 16;
    localparam int NDESC  = 16384;

    typedef logic [13:0] pqm_idx_t;
    typedef logic [14:0] pqm_cnt_t;
    typedef logic [5:0]  pqm_qnum_t;

    // Queue partition
    localparam pqm_qnum_t Q_RXFREE_BASE = 6'h00;
    localparam pqm_qnum_t Q_TXSUB_BASE  = 6'h10;
    localparam pqm_qnum_t Q_TXCMP_BASE  = 6'h18;
    localparam pqm_qnum_t Q_RXCMP_BASE  = 6'h1A;
    localparam pqm_qnum_t Q_GP_BASE     = 6'h1C;

    // Byte addresses of the register map
    localparam logic [13:0] A_STATUS   = 14'h0000;
    localparam logic [13:0] A_DIVERT   = 14'h0008;
    localparam logic [13:0] A_LBASE1   = 14'h0010;
    localparam logic [13:0] A_LBASE2   = 14'h0014;
    localparam logic [13:0] A_LSIZE1   = 14'h0018;
    localparam logic [13:0] A_LSIZE2   = 14'h001C;
    localparam logic [13:0] A_LADDR    = 14'h0020;
    localparam logic [13:0] A_PEND_LO  = 14'h0024;
    localparam logic [13:0] A_PEND_HI  = 14'h0028;
    localparam logic [13:0] A_REGION   = 14'h1000;
    localparam logic [13:0] A_QUEUE    = 14'h2000;
    localparam logic [3:0]  RREG_BASE  = 4'h0;
    localparam logic [3:0]  RREG_COUNT = 4'h4;
    localparam logic [3:0]  RREG_CTRL  = 4'h8;
    localparam logic [3:0]  QREG_COUNT = 4'h0;
    localparam logic [3:0]  QREG_PEEK  = 4'h8;
    localparam logic [3:0]  QREG_PUSHPOP = 4'hC;

    // Field positions
    localparam int DIV_SRC_LSB   = 0;
    localparam int DIV_DST_LSB   = 16;
    localparam int DIV_HEAD_BIT  = 31;
    localparam int CTRL_SIZE_LSB = 16;
    localparam logic [4:0] DESC_MIN_SHIFT = 5'h05;
    localparam logic [3:0] BE_FULL = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUS  = 3'b010,
        ST_DMA  = 3'b100
    } pqm_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [13:0] address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } pqm_avm_req_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  port;
        pqm_qnum_t   queue;
        logic [31:0] ptr;
    } pqm_dma_req_s;

    typedef struct packed {
        logic [31:0] ptr;
        logic        empty;
        logic        err;
    } pqm_dma_rsp_s;

    typedef struct packed {
        pqm_idx_t head;
        pqm_idx_t tail;
        pqm_cnt_t count;
    } pqm_queue_s;

    typedef struct packed {
        pqm_state_e                      st;
        logic                            prio;
        pqm_queue_s [NQ-1:0]             q;
        logic [31:0]                     lbase1;
        logic [31:0]                     lbase2;
        pqm_cnt_t                        lsize1;
        logic [NREGN-1:0][31:0]          rbase;
        logic [NREGN-1:0][14:0]          rcount;
        logic [NREGN-1:0][13:0]          rstart;
        logic [NREGN-1:0][3:0]           rsize;
        logic                            bad_push;
        logic [31:0]                     laddr;
        logic [31:0]                     rdata;
        pqm_dma_rsp_s                    dma_rsp;
        logic                            cmpl_irq;
    } pqm_state_s;

    localparam pqm_state_s RST_STATE = '{st: ST_IDLE, default: '0};

endpackage

// ---- verilog/pqm_queue_manager.sv ----
// Packet queue manager: 64 descriptor queues behind an Avalon-MM slave
// Function
// - Exactly 64 independent queues of descriptor pointers.
// - Queues 0 to 15 are receive free queues shared by all ports.
// - Queues 16 to 23 are transmit submit pairs, one pair per port.
// - Pushes onto queues 24 and 25 raise the completion interrupt.
// - Pushes onto queues 26 and 27 raise the completion interrupt.
// - Queues 28 to 63 are general purpose and never interrupt.
// - Writing a queue's push/pop register appends at the tail.
// - Reading push/pop returns and removes the head pointer.
// - Each queue has its own address block decoded from its number.
// - Queue access is by registers or the DMA port; no list memory setup needed.
// - Diversion register moves a whole source queue onto a destination.
// - Diversion option places moved contents at tail or at head.
// - Up to 16 descriptor regions, one descriptor size per region.
// - At most 16K descriptors, each known by its internal index.
// - Link state lives in internal link storage; linking RAM is only addressed in A_LADDR.
// - Two registers hold word aligned linking RAM region starts.
// - Region one size register counts descriptors; bytes are four times.
// - Region two size register is read-only; it takes the remaining indices.
// - Low five pointer bits carry size; descriptors 32-byte aligned.
// - Completion interrupt is not maskable and goes straight out.
`timescale 1ns/10ps
module pqm_queue_manager (
    // Clock, reset, enable
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_ce,
    // Avalon-MM register slave
    input  wire pqm_pkg::pqm_avm_req_s i_avm,
    output logic                       o_waitrequest,
    output logic [31:0]                o_readdata,
    // DMA port client
    input  wire pqm_pkg::pqm_dma_req_s i_dma,
    output logic                       o_dma_ready,
    output pqm_pkg::pqm_dma_rsp_s      o_dma_rsp,
    // Completion interrupt
    output logic                       o_cmpl_irq
);

    pqm_pkg::pqm_state_s s_r;
    pqm_pkg::pqm_state_s s_nxt;

    // Descriptor pointers and next links, indexed by descriptor index
    logic [31:0]       ptr_mem [pqm_pkg::NDESC];
    pqm_pkg::pqm_idx_t nxt_mem [pqm_pkg::NDESC];

    logic              ptr_we;
    pqm_pkg::pqm_idx_t ptr_wa;
    logic [31:0]       ptr_wd;
    logic              nxt_we;
    pqm_pkg::pqm_idx_t nxt_wa;
    pqm_pkg::pqm_idx_t nxt_wd;

    logic              take_bus;
    logic              take_dma;
    logic              do_push;
    logic              do_pop;
    logic              do_peek;
    logic              port_err;
    pqm_pkg::pqm_qnum_t op_q;
    logic [31:0]       op_ptr;
    logic              bus_wr;
    logic              is_qblk;
    logic              is_rblk;
    logic [3:0]        sub;
    logic [3:0]        rsel;

    logic              hit;
    pqm_pkg::pqm_idx_t hit_idx;
    logic [31:0]       base_addr;
    logic [31:0]       off;
    logic [31:0]       shf;
    logic [15:0]       total;
    logic [63:0]       pend;

    // Byte address in linking RAM of a descriptor's link word
    function automatic logic [31:0] link_addr(
        input pqm_pkg::pqm_idx_t idx,
        input logic [31:0]       b1,
        input logic [31:0]       b2,
        input pqm_pkg::pqm_cnt_t sz1
    );
        pqm_pkg::pqm_idx_t rel;
        rel = idx - sz1[13:0];
        if ({1'b0, idx} < sz1) begin
            link_addr = b1 + {16'h0000, idx, 2'b00};
        end else begin
            link_addr = b2 + {16'h0000, rel, 2'b00};
        end
    endfunction

    // Request decode
    always_comb begin
        bus_wr  = i_avm.write & (i_avm.byteenable == pqm_pkg::BE_FULL);
        is_qblk = i_avm.address[13:10] == pqm_pkg::A_QUEUE[13:10];
        is_rblk = i_avm.address[13:8] == pqm_pkg::A_REGION[13:8];
        sub     = i_avm.address[3:0];
        rsel    = i_avm.address[7:4];
        take_bus = (s_r.st == pqm_pkg::ST_IDLE)
                   & (i_avm.read | i_avm.write)
                   & (~s_r.prio | ~i_dma.valid);
        take_dma = (s_r.st == pqm_pkg::ST_IDLE) & i_dma.valid & ~take_bus;
        if (take_bus) begin
            op_q    = i_avm.address[9:4];
            op_ptr  = i_avm.writedata;
            do_push = bus_wr & is_qblk & (sub == pqm_pkg::QREG_PUSHPOP);
            do_pop  = i_avm.read & is_qblk & (sub == pqm_pkg::QREG_PUSHPOP);
            do_peek = i_avm.read & is_qblk & (sub == pqm_pkg::QREG_PEEK);
            port_err = 1'b0;
        end else begin
            op_q    = i_dma.queue;
            op_ptr  = i_dma.ptr;
            // Transmit submit pairs belong to one port only
            port_err = (op_q[5:3] == pqm_pkg::Q_TXSUB_BASE[5:3])
                       & (op_q[2:1] != i_dma.port);
            do_push = take_dma & i_dma.write & ~port_err;
            do_pop  = take_dma & ~i_dma.write & ~port_err;
            do_peek = 1'b0;
        end
    end

    // Map a pushed pointer to its descriptor index through the regions
    always_comb begin
        hit       = 1'b0;
        hit_idx   = '0;
        off       = '0;
        shf       = '0;
        total     = '0;
        base_addr = {op_ptr[31:5], 5'h00};
        for (int r = pqm_pkg::NREGN - 1; r >= 0; r--) begin
            off = base_addr - s_r.rbase[r];
            shf = off >> ({1'b0, s_r.rsize[r]} + pqm_pkg::DESC_MIN_SHIFT);
            if ((base_addr >= s_r.rbase[r]) && (shf < {17'h0, s_r.rcount[r]})
                && (s_r.rcount[r] != '0)) begin
                hit     = 1'b1;
                hit_idx = s_r.rstart[r] + shf[13:0];
            end
            total = total + {1'b0, s_r.rcount[r]};
        end
        for (int k = 0; k < pqm_pkg::NQ; k++) begin
            pend[k] = s_r.q[k].count != '0;
        end
    end

    // Next state
    always_comb begin
        s_nxt  = s_r;
        s_nxt.cmpl_irq = 1'b0;
        ptr_we = 1'b0;
        ptr_wa = hit_idx;
        ptr_wd = op_ptr;
        nxt_we = 1'b0;
        nxt_wa = '0;
        nxt_wd = '0;
        case (s_r.st)
            pqm_pkg::ST_IDLE: begin
                if (take_bus | take_dma) begin
                    s_nxt.st   = take_bus ? pqm_pkg::ST_BUS : pqm_pkg::ST_DMA;
                    s_nxt.prio = take_bus;
                    s_nxt.rdata = '0;
                    s_nxt.dma_rsp = '{ptr: 32'h0000_0000, empty: 1'b0,
                                      err: port_err};
                end
                // Append at the tail of the addressed queue
                if (do_push & ~hit) begin
                    s_nxt.bad_push = 1'b1;
                    s_nxt.dma_rsp.err = 1'b1;
                end else if (do_push) begin
                    ptr_we = 1'b1;
                    if (s_r.q[op_q].count == '0) begin
                        s_nxt.q[op_q].head = hit_idx;
                    end else begin
                        nxt_we = 1'b1;
                        nxt_wa = s_r.q[op_q].tail;
                        nxt_wd = hit_idx;
                    end
                    s_nxt.q[op_q].tail  = hit_idx;
                    s_nxt.q[op_q].count = s_r.q[op_q].count + 15'h0001;
                    s_nxt.laddr = link_addr(hit_idx, s_r.lbase1,
                                            s_r.lbase2, s_r.lsize1);
                    // Reserved completion queues interrupt, unmasked
                    if (op_q[5:2] == pqm_pkg::Q_TXCMP_BASE[5:2]) begin
                        s_nxt.cmpl_irq = 1'b1;
                    end
                end
                // Hand out the head; a pop also unlinks it
                if (do_pop | do_peek) begin
                    if (s_r.q[op_q].count == '0) begin
                        s_nxt.dma_rsp.empty = 1'b1;
                    end else begin
                        s_nxt.rdata = ptr_mem[s_r.q[op_q].head];
                        s_nxt.dma_rsp.ptr = ptr_mem[s_r.q[op_q].head];
                        if (do_pop) begin
                            s_nxt.q[op_q].head = nxt_mem[s_r.q[op_q].head];
                            s_nxt.q[op_q].count =
                                s_r.q[op_q].count - 15'h0001;
                            s_nxt.laddr = link_addr(s_r.q[op_q].head,
                                s_r.lbase1, s_r.lbase2, s_r.lsize1);
                        end
                    end
                end
                if (take_bus & is_qblk & i_avm.read
                    & (sub == pqm_pkg::QREG_COUNT)) begin
                    s_nxt.rdata = {17'h0, s_r.q[op_q].count};
                end
                if (take_bus & ~is_qblk) begin
                    if (i_avm.read) begin
                        case (i_avm.address)
                            pqm_pkg::A_STATUS:
                                s_nxt.rdata = {31'h0, s_r.bad_push};
                            pqm_pkg::A_LBASE1:  s_nxt.rdata = s_r.lbase1;
                            pqm_pkg::A_LBASE2:  s_nxt.rdata = s_r.lbase2;
                            pqm_pkg::A_LSIZE1:
                                s_nxt.rdata = {17'h0, s_r.lsize1};
                            pqm_pkg::A_LSIZE2:
                                s_nxt.rdata = {16'h0,
                                               total - {1'b0, s_r.lsize1}};
                            pqm_pkg::A_LADDR:   s_nxt.rdata = s_r.laddr;
                            pqm_pkg::A_PEND_LO: s_nxt.rdata = pend[31:0];
                            pqm_pkg::A_PEND_HI: s_nxt.rdata = pend[63:32];
                            default: begin
                                if (is_rblk && sub == pqm_pkg::RREG_BASE) begin
                                    s_nxt.rdata = s_r.rbase[rsel];
                                end else if (is_rblk &&
                                             sub == pqm_pkg::RREG_COUNT) begin
                                    s_nxt.rdata = {17'h0, s_r.rcount[rsel]};
                                end else if (is_rblk &&
                                             sub == pqm_pkg::RREG_CTRL) begin
                                    s_nxt.rdata = {12'h000, s_r.rsize[rsel],
                                                   2'b00, s_r.rstart[rsel]};
                                end
                            end
                        endcase
                    end else if (bus_wr) begin
                        case (i_avm.address)
                            pqm_pkg::A_STATUS: begin
                                if (i_avm.writedata[0]) begin
                                    s_nxt.bad_push = 1'b0;
                                end
                            end
                            pqm_pkg::A_LBASE1:
                                s_nxt.lbase1 = {i_avm.writedata[31:2], 2'b00};
                            pqm_pkg::A_LBASE2:
                                s_nxt.lbase2 = {i_avm.writedata[31:2], 2'b00};
                            pqm_pkg::A_LSIZE1:
                                s_nxt.lsize1 = i_avm.writedata[14:0];
                            pqm_pkg::A_DIVERT: begin
                                s_nxt = divert(s_nxt, i_avm.writedata);
                            end
                            default: begin
                                if (is_rblk && sub == pqm_pkg::RREG_BASE) begin
                                    s_nxt.rbase[rsel] =
                                        {i_avm.writedata[31:5], 5'h00};
                                end else if (is_rblk &&
                                             sub == pqm_pkg::RREG_COUNT) begin
                                    s_nxt.rcount[rsel] =
                                        i_avm.writedata[14:0];
                                end else if (is_rblk &&
                                             sub == pqm_pkg::RREG_CTRL) begin
                                    s_nxt.rstart[rsel] =
                                        i_avm.writedata[13:0];
                                    s_nxt.rsize[rsel] = i_avm.writedata[
                                        pqm_pkg::CTRL_SIZE_LSB +: 4];
                                end
                            end
                        endcase
                        if (i_avm.address == pqm_pkg::A_DIVERT) begin
                            nxt_we = div_link_we(s_r, i_avm.writedata);
                            nxt_wa = div_link_wa(s_r, i_avm.writedata);
                            nxt_wd = div_link_wd(s_r, i_avm.writedata);
                        end
                    end
                end
            end
            pqm_pkg::ST_BUS: s_nxt.st = pqm_pkg::ST_IDLE;
            pqm_pkg::ST_DMA: s_nxt.st = pqm_pkg::ST_IDLE;
            default:         s_nxt.st = pqm_pkg::ST_IDLE;
        endcase
    end

    // Whole queue move; lists are spliced, no pointer is copied
    function automatic pqm_pkg::pqm_state_s divert(
        input pqm_pkg::pqm_state_s s,
        input logic [31:0]         w
    );
        pqm_pkg::pqm_qnum_t src;
        pqm_pkg::pqm_qnum_t dst;
        src = w[pqm_pkg::DIV_SRC_LSB +: 6];
        dst = w[pqm_pkg::DIV_DST_LSB +: 6];
        divert = s;
        if (src != dst && s.q[src].count != '0) begin
            if (s.q[dst].count == '0) begin
                divert.q[dst] = s.q[src];
            end else if (w[pqm_pkg::DIV_HEAD_BIT]) begin
                divert.q[dst].head = s.q[src].head;
            end else begin
                divert.q[dst].tail = s.q[src].tail;
            end
            divert.q[dst].count = s.q[dst].count + s.q[src].count;
            divert.q[src].count = '0;
        end
    endfunction

    function automatic logic div_link_we(
        input pqm_pkg::pqm_state_s s,
        input logic [31:0]         w
    );
        pqm_pkg::pqm_qnum_t src;
        pqm_pkg::pqm_qnum_t dst;
        src = w[pqm_pkg::DIV_SRC_LSB +: 6];
        dst = w[pqm_pkg::DIV_DST_LSB +: 6];
        div_link_we = (src != dst) && (s.q[src].count != '0)
                      && (s.q[dst].count != '0);
    endfunction

    function automatic pqm_pkg::pqm_idx_t div_link_wa(
        input pqm_pkg::pqm_state_s s,
        input logic [31:0]         w
    );
        pqm_pkg::pqm_qnum_t src;
        pqm_pkg::pqm_qnum_t dst;
        src = w[pqm_pkg::DIV_SRC_LSB +: 6];
        dst = w[pqm_pkg::DIV_DST_LSB +: 6];
        div_link_wa = w[pqm_pkg::DIV_HEAD_BIT] ? s.q[src].tail
                                               : s.q[dst].tail;
    endfunction

    function automatic pqm_pkg::pqm_idx_t div_link_wd(
        input pqm_pkg::pqm_state_s s,
        input logic [31:0]         w
    );
        pqm_pkg::pqm_qnum_t src;
        pqm_pkg::pqm_qnum_t dst;
        src = w[pqm_pkg::DIV_SRC_LSB +: 6];
        dst = w[pqm_pkg::DIV_DST_LSB +: 6];
        div_link_wd = w[pqm_pkg::DIV_HEAD_BIT] ? s.q[dst].head
                                               : s.q[src].head;
    endfunction

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= pqm_pkg::RST_STATE;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    // Link storage carries no reset; queue counts say what is valid
    always_ff @(posedge i_clk) begin
        if (i_ce && ptr_we) begin
            ptr_mem[ptr_wa] <= ptr_wd;
        end
        if (i_ce && nxt_we) begin
            nxt_mem[nxt_wa] <= nxt_wd;
        end
    end

    assign o_waitrequest = s_r.st != pqm_pkg::ST_BUS;
    assign o_readdata    = s_r.rdata;
    assign o_dma_ready   = s_r.st == pqm_pkg::ST_DMA;
    assign o_dma_rsp     = s_r.dma_rsp;
    assign o_cmpl_irq    = s_r.cmpl_irq;

endmodule // pqm_queue_manager
